// File: bit_xchg_stack_instr_exec.sv
`timescale 1ns/1ps
`default_nettype none
`include "xbit_consts.svh"

module bit_xchg_stack_instr_exec (
  // clock and reset
  input wire logic clock_in,
  input wire logic rst_b_in,
  // instruction issue
  input wire logic start_in,
  input wire xbit_pkg::cmd_s cmd_in,
  output logic busy_out,
  output logic done_out,
  output logic [7:0] states_out,
  output logic [2:0] bytes_out,
  output logic [31:0] result_out,
  // architectural state
  output logic carry_flag_out,
  output logic [7:0] accumulator_out,
  output logic [15:0] stack_pointer_out,
  // memory path, read data valid in the cycle the address is shown
  output xbit_pkg::mem_s mem_out,
  input wire logic [7:0] mem_rdata_in
);

  xbit_pkg::state_s cur_ff, nxt_cur;

  function automatic logic [7:0] rd_extra(input xbit_pkg::loc_e l);
    rd_extra = (l == xbit_pkg::loc_io) ? `RD_IO_EXTRA :
               (l == xbit_pkg::loc_sfr) ? `RD_SFR_EXTRA : 8'h00;
  endfunction

  function automatic logic [7:0] wr_extra(input xbit_pkg::loc_e l);
    wr_extra = (l == xbit_pkg::loc_io) ? `WR_IO_EXTRA :
               (l == xbit_pkg::loc_sfr) ? `WR_SFR_EXTRA : 8'h00;
  endfunction

  // binary form of a pair, else source form
  function automatic logic [7:0] pick(input logic bin, input logic [7:0] b, input logic [7:0] s);
    pick = bin ? b : s;
  endfunction

  function automatic logic [7:0] states_of(input xbit_pkg::cmd_s c);
    logic [7:0] b;
    logic [7:0] x;
    logic [7:0] n;
    logic bn;
    bn = !c.source_mode;
    x = 8'h00;
    n = {4'h0, c.wait_n};
    b = `ST_ONE;
    unique case (c.op)
      xbit_pkg::op_clr_c, xbit_pkg::op_set_c, xbit_pkg::op_cpl_c: b = `ST_ONE;
      xbit_pkg::op_clr_b, xbit_pkg::op_set_b, xbit_pkg::op_cpl_b, xbit_pkg::op_mov_bc: begin
        b = c.long_form ? pick(bn, 8'h04, 8'h03) : 8'h02;
        x = wr_extra(c.loc);
      end
      xbit_pkg::op_and, xbit_pkg::op_andn, xbit_pkg::op_or, xbit_pkg::op_orn,
      xbit_pkg::op_mov_cb: begin
        b = c.long_form ? pick(bn, 8'h03, 8'h02) : `ST_ONE;
        x = rd_extra(c.loc);
      end
      xbit_pkg::op_xch: begin
        if (c.src == xbit_pkg::src_reg) begin
          b = pick(bn, 8'h03, 8'h04);
        end else if (c.src == xbit_pkg::src_dir) begin
          b = `ST_XCH_DIR;
          x = wr_extra(c.loc);
        end else begin
          b = pick(bn, 8'h04, 8'h05);
        end
      end
      xbit_pkg::op_nibble_exchange_op: b = pick(bn, 8'h04, 8'h05);
      xbit_pkg::op_push: begin
        if (c.src == xbit_pkg::src_dir) begin
          b = `ST_PUSH_DIR;
          x = rd_extra(c.loc);
        end else if (c.src == xbit_pkg::src_imm16) begin
          b = `ST_PUSH_IMM16;
        end else if (c.size == 3'h4) begin
          b = pick(bn, 8'h09, 8'h08);
        end else if (c.size == 3'h2) begin
          b = pick(bn, 8'h05, 8'h04);
        end else begin
          b = pick(bn, 8'h04, 8'h03);
        end
      end
      xbit_pkg::op_pop: begin
        if (c.src == xbit_pkg::src_dir) begin
          b = `ST_POP_DIR;
          x = rd_extra(c.loc);
        end else if (c.size == 3'h4) begin
          b = pick(bn, 8'h09, 8'h08);
        end else if (c.size == 3'h2) begin
          b = pick(bn, 8'h05, 8'h04);
        end else begin
          b = pick(bn, 8'h03, 8'h02);
        end
      end
      xbit_pkg::op_ext: begin
        b = c.base_states;
        if (c.loc == xbit_pkg::loc_ext) begin
          // class follows operand width
          if (c.size == 3'h1) x = n + `EXT_BYTE_ADD;
          else if (c.size == 3'h2) x = 8'((n + `EXT_WORD_ADD) << 1);
          else x = 8'((n + `EXT_DWORD_ADD) << 2);
        end
      end
    endcase
    states_of = 8'(b + x);
  endfunction

  function automatic logic [2:0] bytes_of(input xbit_pkg::cmd_s c);
    logic bn;
    bn = !c.source_mode;
    bytes_of = 3'h2;
    unique case (c.op)
      xbit_pkg::op_clr_c, xbit_pkg::op_set_c, xbit_pkg::op_cpl_c: bytes_of = 3'h1;
      xbit_pkg::op_xch, xbit_pkg::op_nibble_exchange_op:
        bytes_of = (c.src == xbit_pkg::src_dir) ? 3'h2 : (bn ? 3'h1 : 3'h2);
      xbit_pkg::op_push, xbit_pkg::op_pop: begin
        if (c.src == xbit_pkg::src_dir) bytes_of = 3'h2;
        else if (c.src == xbit_pkg::src_imm16) bytes_of = bn ? 3'h5 : 3'h4;
        else if (c.src == xbit_pkg::src_imm) bytes_of = bn ? 3'h4 : 3'h3;
        else bytes_of = bn ? 3'h3 : 3'h2;
      end
      xbit_pkg::op_ext: bytes_of = 3'h0;
      default: bytes_of = c.long_form ? (bn ? 3'h4 : 3'h3) : 3'h2;
    endcase
  endfunction

  // most significant byte goes to the lowest stack address
  function automatic logic [7:0] byte_sel(input logic [31:0] v, input logic [2:0] sz,
                                          input logic [2:0] k);
    logic [2:0] s;
    s = 3'(sz - 3'h1 - k);
    byte_sel = v[{s[1:0], 3'h0} +: 8];
  endfunction

  function automatic xbit_pkg::mem_s mem_op(input logic we, input logic [15:0] a,
                                            input logic [7:0] d);
    mem_op = '{req: 1'b1, we: we, addr: a, wdata: d};
  endfunction

  always_comb begin
    logic [7:0] d;
    logic bv;
    xbit_pkg::cmd_s c;
    d = mem_rdata_in;
    c = cur_ff.cmd;
    bv = d[c.bit_pos];
    nxt_cur = cur_ff;
    nxt_cur.done = 1'b0;
    nxt_cur.mem = '0;
    unique case (cur_ff.fsm)
      xbit_pkg::st_idle: begin
        if (start_in) begin
          nxt_cur.fsm = xbit_pkg::st_run;
          nxt_cur.cmd = cmd_in;
          nxt_cur.cnt = 8'h01;
          nxt_cur.idx = 3'h1;
          nxt_cur.total = states_of(cmd_in);
          nxt_cur.nbytes = bytes_of(cmd_in);
          nxt_cur.result = '0;
          if (cmd_in.op == xbit_pkg::op_clr_c) nxt_cur.carry = 1'b0;
          else if (cmd_in.op == xbit_pkg::op_set_c) nxt_cur.carry = 1'b1;
          else if (cmd_in.op == xbit_pkg::op_cpl_c) nxt_cur.carry = ~cur_ff.carry;
          else if (cmd_in.op == xbit_pkg::op_push) begin
            nxt_cur.base = 16'(cur_ff.sp + 16'h0001);
            nxt_cur.sp = 16'(cur_ff.sp + {13'h0, cmd_in.size});
            if (cmd_in.src == xbit_pkg::src_dir)
              nxt_cur.mem = mem_op(1'b0, cmd_in.addr, 8'h00);
            else
              nxt_cur.mem = mem_op(1'b1, 16'(cur_ff.sp + 16'h0001),
                                   byte_sel(cmd_in.data, cmd_in.size, 3'h0));
          end else if (cmd_in.op == xbit_pkg::op_pop) begin
            nxt_cur.base = 16'(cur_ff.sp - {13'h0, cmd_in.size} + 16'h0001);
            nxt_cur.sp = 16'(cur_ff.sp - {13'h0, cmd_in.size});
            nxt_cur.idx = 3'h0;
            nxt_cur.mem = mem_op(1'b0, 16'(cur_ff.sp - {13'h0, cmd_in.size} + 16'h0001),
                                 8'h00);
          end else if (cmd_in.op == xbit_pkg::op_nibble_exchange_op) begin
            nxt_cur.mem = mem_op(1'b0, {8'h00, cmd_in.addr[7:0]}, 8'h00);
          end else if (cmd_in.op != xbit_pkg::op_ext &&
                       !(cmd_in.op == xbit_pkg::op_xch && cmd_in.src == xbit_pkg::src_reg)) begin
            nxt_cur.mem = mem_op(1'b0, cmd_in.addr, 8'h00);
          end
        end
      end
      xbit_pkg::st_run: begin
        if (cur_ff.cnt == 8'h01) begin
          unique case (c.op)
            xbit_pkg::op_and: nxt_cur.carry = cur_ff.carry & bv;
            xbit_pkg::op_andn: nxt_cur.carry = cur_ff.carry & ~bv;
            xbit_pkg::op_or: nxt_cur.carry = cur_ff.carry | bv;
            xbit_pkg::op_orn: nxt_cur.carry = cur_ff.carry | ~bv;
            xbit_pkg::op_mov_cb: nxt_cur.carry = bv;
            xbit_pkg::op_clr_b, xbit_pkg::op_set_b, xbit_pkg::op_cpl_b,
            xbit_pkg::op_mov_bc: begin
              d[c.bit_pos] = (c.op == xbit_pkg::op_clr_b) ? 1'b0 :
                             (c.op == xbit_pkg::op_set_b) ? 1'b1 :
                             (c.op == xbit_pkg::op_cpl_b) ? ~bv : cur_ff.carry;
              nxt_cur.mem = mem_op(1'b1, c.addr, d);
            end
            xbit_pkg::op_xch: begin
              nxt_cur.result = {24'h0, cur_ff.acc};
              if (c.src == xbit_pkg::src_reg) begin
                nxt_cur.acc = c.data[7:0];
              end else begin
                nxt_cur.acc = d;
                nxt_cur.mem = mem_op(1'b1, c.addr, cur_ff.acc);
              end
            end
            xbit_pkg::op_nibble_exchange_op: begin
              // upper nibbles on both sides stay put
              nxt_cur.acc = {cur_ff.acc[7:4], d[3:0]};
              nxt_cur.mem = mem_op(1'b1, {8'h00, c.addr[7:0]}, {d[7:4], cur_ff.acc[3:0]});
            end
            default: begin
            end
          endcase
        end
        if (c.op == xbit_pkg::op_push) begin
          if (c.src == xbit_pkg::src_dir) begin
            if (cur_ff.cnt == 8'h01) nxt_cur.mem = mem_op(1'b1, cur_ff.base, d);
          end else if (cur_ff.idx < c.size) begin
            nxt_cur.mem = mem_op(1'b1, 16'(cur_ff.base + {13'h0, cur_ff.idx}),
                                 byte_sel(c.data, c.size, cur_ff.idx));
            nxt_cur.idx = 3'(cur_ff.idx + 3'h1);
          end
        end
        if (c.op == xbit_pkg::op_pop && cur_ff.idx < c.size) begin
          nxt_cur.result = {cur_ff.result[23:0], d};
          nxt_cur.idx = 3'(cur_ff.idx + 3'h1);
          if (c.src == xbit_pkg::src_dir)
            nxt_cur.mem = mem_op(1'b1, c.addr, d);
          else if (3'(cur_ff.idx + 3'h1) < c.size)
            nxt_cur.mem = mem_op(1'b0, 16'(cur_ff.base + {13'h0, cur_ff.idx} + 16'h0001),
                                 8'h00);
        end
        // the full state count is spent even when the work ends early
        if (cur_ff.cnt == cur_ff.total) begin
          nxt_cur.fsm = xbit_pkg::st_idle;
          nxt_cur.done = 1'b1;
        end else begin
          nxt_cur.cnt = 8'(cur_ff.cnt + 8'h01);
        end
      end
    endcase
  end

  always_ff @(posedge clock_in) begin
    if (!rst_b_in) begin
      cur_ff <= '0;
      cur_ff.fsm <= xbit_pkg::st_idle;
      cur_ff.sp <= `SP_RST;
      cur_ff.acc <= `ACC_RST;
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  assign busy_out = (cur_ff.fsm == xbit_pkg::st_run);
  assign done_out = cur_ff.done;
  assign states_out = cur_ff.total;
  assign bytes_out = cur_ff.nbytes;
  assign result_out = cur_ff.result;
  assign carry_flag_out = cur_ff.carry;
  assign accumulator_out = cur_ff.acc;
  assign stack_pointer_out = cur_ff.sp;
  assign mem_out = cur_ff.mem;

  // checks
  default clocking @(posedge clock_in); endclocking
  default disable iff (!rst_b_in);

  logic go;
  logic first;
  xbit_pkg::cmd_s ci;
  assign go = start_in && !busy_out;
  assign first = busy_out && (cur_ff.cnt == 8'h01);
  assign ci = cmd_in;

  a_ext_byte_add: assert property (go && ci.op == xbit_pkg::op_ext && ci.loc == xbit_pkg::loc_ext && ci.size == 3'h1 |=> states_out == 8'($past(ci.base_states) + $past(ci.wait_n) + 8'h02)) else $error("ext byte states wrong");
  a_ext_word_add: assert property (go && ci.op == xbit_pkg::op_ext && ci.loc == xbit_pkg::loc_ext && ci.size == 3'h2 |=> states_out == 8'($past(ci.base_states) + 2 * ($past(ci.wait_n) + 1))) else $error("ext word states wrong");
  a_ext_dword_add: assert property (go && ci.op == xbit_pkg::op_ext && ci.loc == xbit_pkg::loc_ext && ci.size == 3'h4 |=> states_out == 8'($past(ci.base_states) + 4 * ($past(ci.wait_n) + 2))) else $error("ext dword states wrong");
  a_bit_read_sfr: assert property (go && ci.op == xbit_pkg::op_and && !ci.long_form && ci.loc == xbit_pkg::loc_sfr |=> states_out == 8'h03) else $error("bit read extra wrong");
  a_bit_write_io: assert property (go && ci.op == xbit_pkg::op_set_b && !ci.long_form && ci.loc == xbit_pkg::loc_io |=> states_out == 8'h04) else $error("bit write extra wrong");
  a_and_carry: assert property (first && cur_ff.cmd.op == xbit_pkg::op_and |=> carry_flag_out == ($past(carry_flag_out) & $past(mem_rdata_in[cur_ff.cmd.bit_pos]))) else $error("and carry wrong");
  a_andn_carry: assert property (first && cur_ff.cmd.op == xbit_pkg::op_andn |=> carry_flag_out == ($past(carry_flag_out) & ~$past(mem_rdata_in[cur_ff.cmd.bit_pos]))) else $error("and-not carry wrong");
  a_or_carry: assert property (first && cur_ff.cmd.op == xbit_pkg::op_or |=> carry_flag_out == ($past(carry_flag_out) | $past(mem_rdata_in[cur_ff.cmd.bit_pos]))) else $error("or carry wrong");
  a_orn_carry: assert property (first && cur_ff.cmd.op == xbit_pkg::op_orn |=> carry_flag_out == ($past(carry_flag_out) | ~$past(mem_rdata_in[cur_ff.cmd.bit_pos]))) else $error("or-not carry wrong");
  a_mov_to_carry: assert property (first && cur_ff.cmd.op == xbit_pkg::op_mov_cb |=> carry_flag_out == $past(mem_rdata_in[cur_ff.cmd.bit_pos])) else $error("bit to carry wrong");
  a_carry_to_bit: assert property (first && cur_ff.cmd.op == xbit_pkg::op_mov_bc |=> mem_out.we && mem_out.wdata[cur_ff.cmd.bit_pos] == carry_flag_out) else $error("carry to bit wrong");
  a_xch_dir_time: assert property (go && ci.op == xbit_pkg::op_xch && ci.src == xbit_pkg::src_dir && ci.loc == xbit_pkg::loc_ram |=> states_out == 8'h03 && bytes_out == 3'h2 ##3 done_out) else $error("direct exchange timing wrong");
  a_xch_ind_time: assert property (go && ci.op == xbit_pkg::op_xch && ci.src == xbit_pkg::src_ind |=> states_out == ($past(ci.source_mode) ? 8'h05 : 8'h04)) else $error("indirect exchange states wrong");
  a_nibble_exchange_op_nibble: assert property (first && cur_ff.cmd.op == xbit_pkg::op_nibble_exchange_op |=> accumulator_out[7:4] == $past(accumulator_out[7:4]) && accumulator_out[3:0] == $past(mem_rdata_in[3:0]) && mem_out.addr[15:8] == 8'h00) else $error("nibble exchange wrong");
  a_push_sp: assert property (go && ci.op == xbit_pkg::op_push |=> stack_pointer_out == 16'($past(stack_pointer_out) + $past(ci.size))) else $error("push pointer wrong");
  a_pop_sp: assert property (go && ci.op == xbit_pkg::op_pop |=> stack_pointer_out == 16'($past(stack_pointer_out) - $past(ci.size))) else $error("pop pointer wrong");
  a_push_imm16: assert property (go && ci.op == xbit_pkg::op_push && ci.src == xbit_pkg::src_imm16 |=> states_out == 8'h05 && bytes_out == ($past(ci.source_mode) ? 3'h4 : 3'h5)) else $error("push imm16 timing wrong");
  a_push_word: assert property (go && ci.op == xbit_pkg::op_push && ci.src == xbit_pkg::src_reg && ci.size == 3'h2 && !ci.source_mode |=> states_out == 8'h05 && bytes_out == 3'h3) else $error("push word timing wrong");
  a_set_carry: assert property (go && ci.op == xbit_pkg::op_set_c |=> carry_flag_out && busy_out ##1 done_out && !busy_out) else $error("set carry wrong");
  a_push_first: assert property (go && ci.op == xbit_pkg::op_push && ci.src != xbit_pkg::src_dir |=> mem_out.we && mem_out.addr == 16'($past(stack_pointer_out) + 16'h0001)) else $error("push first byte misplaced");

  c_push_dword: cover property (go && ci.op == xbit_pkg::op_push && ci.size == 3'h4);
  c_pop_word: cover property (go && ci.op == xbit_pkg::op_pop && ci.size == 3'h2);
  c_ext_dword: cover property (go && ci.op == xbit_pkg::op_ext && ci.loc == xbit_pkg::loc_ext && ci.size == 3'h4);
  c_nibble_exchange_op_done: cover property (busy_out && cur_ff.cmd.op == xbit_pkg::op_nibble_exchange_op ##1 done_out);

endmodule // bit_xchg_stack_instr_exec
`default_nettype wire

// File: bit_xchg_stack_instr_exec_bench.sv
`timescale 1ns/1ps
`default_nettype none
module bit_xchg_stack_instr_exec_bench;
  logic clock_in = 1'b0;
  logic rst_b_in = 1'b0;
  logic start_in = 1'b0;
  xbit_pkg::cmd_s cmd_in = '0;
  logic busy_out, done_out, carry_flag_out;
  logic [7:0] states_out, accumulator_out, mem_rdata_in;
  logic [2:0] bytes_out;
  logic [31:0] result_out;
  logic [15:0] stack_pointer_out;
  xbit_pkg::mem_s mem_out;
  int failures = 0;
  int comparisons = 0;

  bit_xchg_stack_instr_exec bit_xchg_stack_instr_exec_i (.clock_in(clock_in),
    .rst_b_in(rst_b_in), .start_in(start_in), .cmd_in(cmd_in), .busy_out(busy_out),
    .done_out(done_out), .states_out(states_out), .bytes_out(bytes_out),
    .result_out(result_out), .carry_flag_out(carry_flag_out),
    .accumulator_out(accumulator_out), .stack_pointer_out(stack_pointer_out),
    .mem_out(mem_out), .mem_rdata_in(mem_rdata_in));
  xbit_mem_model xbit_mem_model_i (.clock_in(clock_in), .mem_in(mem_out),
    .rdata_out(mem_rdata_in));

  initial begin
    forever #2.5 clock_in = ~clock_in;
  end

  task automatic cmp(input logic [31:0] act, input logic [31:0] exp);
    comparisons++;
    if (act !== exp) begin
      failures++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, act, exp);
    end
  endtask

  task automatic tally_and_finish;
    if (failures == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // entered and left 1 ns after an edge; the next start may follow done at once
  task automatic run(input xbit_pkg::op_e op, input xbit_pkg::src_e src, input logic sm,
      input logic lf, input logic [2:0] sz, input xbit_pkg::loc_e loc, input logic [15:0] a,
      input logic [31:0] d, input logic [7:0] es, input logic [2:0] eb);
    logic seen;
    int cyc;
    seen = 1'b0;
    cyc = 0;
    cmd_in = '{op:op, src:src, source_mode:sm, long_form:lf, size:sz, loc:loc,
      wait_n:4'h3, base_states:8'h05, addr:a, bit_pos:3'h5, data:d};
    start_in = 1'b1;
    @(posedge clock_in);
    #1 start_in = 1'b0;
    for (int n = 0; n < 40 && !seen; n++) begin
      @(posedge clock_in);
      cyc++;
      #1 seen = (done_out === 1'b1);
    end
    cmp({31'h0, seen}, 32'h1);
    // run length must equal the expected state count
    cmp(cyc, {24'h0, es});
    cmp({31'h0, busy_out}, 32'h0);
    cmp({24'h0, states_out}, {24'h0, es});
    cmp({29'h0, bytes_out}, {29'h0, eb});
  endtask

  task automatic setc(input logic c);
    run(c ? xbit_pkg::op_set_c : xbit_pkg::op_clr_c, xbit_pkg::src_reg, 1'b0, 1'b0, 3'h1,
      xbit_pkg::loc_ram, 16'h0, 32'h0, 8'h01, 3'h1);
    cmp({31'h0, carry_flag_out}, {31'h0, c});
  endtask

  task automatic t_carry;
    setc(1'b0);
    setc(1'b1);
    run(xbit_pkg::op_cpl_c, xbit_pkg::src_reg, 1'b1, 1'b0, 3'h1, xbit_pkg::loc_ram, 16'h0,
      32'h0, 8'h01, 3'h1);
    cmp({31'h0, carry_flag_out}, 32'h0);
  endtask

  task automatic t_bitrd;
    xbit_pkg::op_e ops[5] = '{xbit_pkg::op_and, xbit_pkg::op_andn, xbit_pkg::op_or,
      xbit_pkg::op_orn, xbit_pkg::op_mov_cb};
    logic c, b, e;
    for (int k = 0; k < 5; k++) begin
      for (int v = 0; v < 48; v++) begin
        c = v[0];
        b = v[1];
        xbit_mem_model_i.mem[16'h0020] = b ? 8'h20 : 8'hDF;
        setc(c);
        case (k)
          0: e = c & b;
          1: e = c & ~b;
          2: e = c | b;
          3: e = c | ~b;
          default: e = b;
        endcase
        run(ops[k], xbit_pkg::src_dir, v[2], v[3], 3'h1, xbit_pkg::loc_e'(2'(v / 16)),
          16'h0020, 32'h0, 8'(v[3] ? (v[2] ? 2 : 3) : 1) + 8'(v / 16),
          3'(v[3] ? (v[2] ? 3 : 4) : 2));
        cmp({31'h0, carry_flag_out}, {31'h0, e});
      end
    end
  endtask

  task automatic t_bitwr;
    xbit_pkg::op_e ops[4] = '{xbit_pkg::op_clr_b, xbit_pkg::op_set_b, xbit_pkg::op_cpl_b,
      xbit_pkg::op_mov_bc};
    logic c, ob, nb;
    int l;
    for (int k = 0; k < 4; k++) begin
      for (int v = 0; v < 24; v++) begin
        c = v[0];
        ob = v[1];
        l = v / 8;
        xbit_mem_model_i.mem[16'h0021] = ob ? 8'h7A : 8'h5A;
        setc(c);
        nb = (k == 0) ? 1'b0 : (k == 1) ? 1'b1 : (k == 2) ? ~ob : c;
        run(ops[k], xbit_pkg::src_dir, v[1], v[2], 3'h1, xbit_pkg::loc_e'(2'(l)), 16'h0021,
          32'h0, 8'(v[2] ? (v[1] ? 3 : 4) : 2) + 8'(l + (l != 0)),
          3'(v[2] ? (v[1] ? 3 : 4) : 2));
        cmp({24'h0, xbit_mem_model_i.mem[16'h0021]}, nb ? 32'h7A : 32'h5A);
      end
    end
  endtask

  task automatic t_xch;
    xbit_mem_model_i.mem[16'h0030] = 8'h5A;
    run(xbit_pkg::op_xch, xbit_pkg::src_dir, 1'b0, 1'b0, 3'h1, xbit_pkg::loc_ram, 16'h0030,
      32'h0, 8'h03, 3'h2);
    cmp({24'h0, accumulator_out}, 32'h5A);
    cmp({24'h0, xbit_mem_model_i.mem[16'h0030]}, 32'h00);
    run(xbit_pkg::op_xch, xbit_pkg::src_ind, 1'b0, 1'b0, 3'h1, xbit_pkg::loc_ram, 16'h0030,
      32'h0, 8'h04, 3'h1);
    cmp({24'h0, accumulator_out}, 32'h00);
    run(xbit_pkg::op_xch, xbit_pkg::src_ind, 1'b1, 1'b0, 3'h1, xbit_pkg::loc_ram, 16'h0030,
      32'h0, 8'h05, 3'h2);
    run(xbit_pkg::op_xch, xbit_pkg::src_dir, 1'b1, 1'b0, 3'h1, xbit_pkg::loc_sfr, 16'h0030,
      32'h0, 8'h06, 3'h2);
    cmp({24'h0, accumulator_out}, 32'h00);
    xbit_mem_model_i.mem[16'h0040] = 8'hC3;
    xbit_mem_model_i.mem[16'h1240] = 8'h77;
    run(xbit_pkg::op_nibble_exchange_op, xbit_pkg::src_ind, 1'b0, 1'b0, 3'h1, xbit_pkg::loc_ram, 16'h1240,
      32'h0, 8'h04, 3'h1);
    cmp({24'h0, accumulator_out}, 32'h03);
    cmp({24'h0, xbit_mem_model_i.mem[16'h0040]}, 32'hC0);
    cmp({24'h0, xbit_mem_model_i.mem[16'h1240]}, 32'h77);
  endtask

  task automatic t_stack;
    run(xbit_pkg::op_push, xbit_pkg::src_reg, 1'b0, 1'b0, 3'h2, xbit_pkg::loc_ram, 16'h0,
      32'hABCD, 8'h05, 3'h3);
    cmp({16'h0, stack_pointer_out}, 32'h9);
    cmp({xbit_mem_model_i.mem[16'h8], xbit_mem_model_i.mem[16'h9]}, 32'hABCD);
    run(xbit_pkg::op_push, xbit_pkg::src_reg, 1'b1, 1'b0, 3'h4, xbit_pkg::loc_ram, 16'h0,
      32'h12345678, 8'h08, 3'h2);
    run(xbit_pkg::op_push, xbit_pkg::src_imm16, 1'b1, 1'b0, 3'h2, xbit_pkg::loc_ram, 16'h0,
      32'hBEEF, 8'h05, 3'h4);
    cmp({16'h0, stack_pointer_out}, 32'hF);
    run(xbit_pkg::op_pop, xbit_pkg::src_reg, 1'b0, 1'b0, 3'h2, xbit_pkg::loc_ram, 16'h0,
      32'h0, 8'h05, 3'h3);
    cmp(result_out, 32'hBEEF);
    run(xbit_pkg::op_pop, xbit_pkg::src_reg, 1'b0, 1'b0, 3'h4, xbit_pkg::loc_ram, 16'h0,
      32'h0, 8'h09, 3'h3);
    cmp(result_out, 32'h12345678);
    run(xbit_pkg::op_pop, xbit_pkg::src_reg, 1'b1, 1'b0, 3'h2, xbit_pkg::loc_ram, 16'h0,
      32'h0, 8'h04, 3'h2);
    cmp(result_out, 32'hABCD);
    cmp({16'h0, stack_pointer_out}, 32'h7);
    xbit_mem_model_i.mem[16'h0050] = 8'h3C;
    run(xbit_pkg::op_push, xbit_pkg::src_dir, 1'b0, 1'b0, 3'h1, xbit_pkg::loc_io, 16'h0050,
      32'h0, 8'h03, 3'h2);
    run(xbit_pkg::op_pop, xbit_pkg::src_dir, 1'b0, 1'b0, 3'h1, xbit_pkg::loc_sfr, 16'h0051,
      32'h0, 8'h05, 3'h2);
    cmp({24'h0, xbit_mem_model_i.mem[16'h0051]}, 32'h3C);
  endtask

  // wait 3, base 5: byte, word and dword classes
  task automatic t_ext;
    run(xbit_pkg::op_ext, xbit_pkg::src_dir, 1'b0, 1'b0, 3'h1, xbit_pkg::loc_ext, 16'h0,
      32'h0, 8'h0A, 3'h0);
    run(xbit_pkg::op_ext, xbit_pkg::src_dir, 1'b0, 1'b0, 3'h2, xbit_pkg::loc_ext, 16'h0,
      32'h0, 8'h0D, 3'h0);
    run(xbit_pkg::op_ext, xbit_pkg::src_dir, 1'b1, 1'b0, 3'h4, xbit_pkg::loc_ext, 16'h0,
      32'h0, 8'h19, 3'h0);
  endtask

  initial begin
    repeat (6) @(posedge clock_in);
    #1 rst_b_in = 1'b1;
    cmp({16'h0, stack_pointer_out}, 32'h7);
    t_carry();
    t_xch();
    t_stack();
    t_ext();
    t_bitrd();
    t_bitwr();
    tally_and_finish();
  end

  // whole run is a few thousand cycles
  initial begin
    #200000;
    failures++;
    tally_and_finish();
  end
endmodule // bit_xchg_stack_instr_exec_bench
`default_nettype wire

// File: xbit_consts.svh
`ifndef XBIT_CONSTS_SVH
`define XBIT_CONSTS_SVH

// reset values of the stack pointer and accumulator held here
`define SP_RST 16'h0007
`define ACC_RST 8'h00

// extra states for I/O port and peripheral register operands
`define RD_IO_EXTRA 8'h01
`define RD_SFR_EXTRA 8'h02
`define WR_IO_EXTRA 8'h02
`define WR_SFR_EXTRA 8'h03

// external memory: byte N+2, word 2(N+1), dword 4(N+2)
`define EXT_BYTE_ADD 8'h02
`define EXT_WORD_ADD 8'h01
`define EXT_DWORD_ADD 8'h02

// fixed state counts
`define ST_ONE 8'h01
`define ST_PUSH_IMM16 8'h05
`define ST_XCH_DIR 8'h03
`define ST_PUSH_DIR 8'h02
`define ST_POP_DIR 8'h03

`endif

// File: xbit_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
module xbit_mem_model (
  // clock
  input wire logic clock_in,
  // memory path
  input wire xbit_pkg::mem_s mem_in,
  output logic [7:0] rdata_out
);
  logic [7:0] mem [0:65535];
  logic [7:0] last_ff;
  // idle bus shows inverted last value so stale data never looks valid
  always_comb begin
    rdata_out = (mem_in.req && !mem_in.we) ? mem[mem_in.addr] : ~last_ff;
  end
  // plain always: the bench preloads the array by hierarchical reference
  always @(posedge clock_in) begin
    if (mem_in.req && mem_in.we) begin
      mem[mem_in.addr] <= mem_in.wdata;
    end
  end
  always_ff @(posedge clock_in) begin
    last_ff <= rdata_out;
  end
endmodule // xbit_mem_model
`default_nettype wire

// File: xbit_pkg.sv
`default_nettype none
package xbit_pkg;
  typedef enum logic [4:0] {
    op_clr_c, op_set_c, op_cpl_c,
    op_clr_b, op_set_b, op_cpl_b, op_mov_bc,
    op_and, op_andn, op_or, op_orn, op_mov_cb,
    op_xch, op_nibble_exchange_op, op_push, op_pop, op_ext
  } op_e;
  typedef enum logic [1:0] {loc_ram, loc_io, loc_sfr, loc_ext} loc_e;
  typedef enum logic [2:0] {src_reg, src_dir, src_ind, src_imm, src_imm16} src_e;
  typedef enum logic {st_idle, st_run} fsm_e;
  typedef struct packed {
    op_e op;
    src_e src;
    logic source_mode;
    logic long_form;
    logic [2:0] size;
    loc_e loc;
    logic [3:0] wait_n;
    logic [7:0] base_states;
    logic [15:0] addr;
    logic [2:0] bit_pos;
    logic [31:0] data;
  } cmd_s;
  typedef struct packed {
    logic req;
    logic we;
    logic [15:0] addr;
    logic [7:0] wdata;
  } mem_s;
  typedef struct packed {
    fsm_e fsm;
    cmd_s cmd;
    logic [7:0] cnt;
    logic [7:0] total;
    logic [2:0] nbytes;
    logic [2:0] idx;
    logic [15:0] base;
    logic carry;
    logic [7:0] acc;
    logic [15:0] sp;
    logic [31:0] result;
    mem_s mem;
    logic done;
  } state_s;
endpackage
`default_nettype wire
